// ---- hw/dma_crc_control.sv ----
// CRC control register and data-path steering for a DMA channel stream
`timescale 1ns/100ps
module dma_crc_control
    import crc_ctrl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Source stream from the DMA engine
    input  wire logic        src_valid,
    output logic             src_ready,
    input  wire logic [31:0] src_data,
    input  wire logic [2:0]  src_channel,
    input  wire logic        src_unaligned,
    // Destination stream
    output logic             dst_valid,
    input  wire logic        dst_ready,
    output logic      [31:0] dst_data,
    // Feed to the CRC engine, presented MSb first unless bit reflection is set
    output logic             crc_feed_valid,
    output logic      [31:0] crc_feed_data,
    output logic             crc_ip_mode,
    output logic      [4:0]  crc_poly_len,
    output logic             crc_append
);
    localparam int LW = $clog2(DEPTH) + 1;

    initial begin
        // The status word keeps at least one zero bit between level and flag
        if (DEPTH < 2 || DEPTH > 8192 || (1 << $clog2(DEPTH)) != DEPTH)
            $error("dma_crc_control: DEPTH must be a power of two from 2 to 8192");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] reorder(input logic [31:0] d, input logic [1:0] sel);
        case (sel)
            ORDER_WORD_SWAP: reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
            ORDER_HALF_SWAP: reorder = {d[15:0], d[31:16]};
            ORDER_HALF_BYTE: reorder = {d[23:16], d[31:24], d[7:0], d[15:8]};
            default:         reorder = d;
        endcase
    endfunction

    function automatic logic [31:0] reflect(input logic [31:0] d);
        for (int i = 0; i < 32; i++)
            reflect[i] = d[31-i];
    endfunction

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    logic [31:0] crc_control;
    logic [15:0] routed_count;
    logic        unaligned_err;
    logic [LW-1:0] fifo_level;

    wire [1:0] byte_order_sel    = crc_control[BYTE_ORDER_LSB+1:BYTE_ORDER_LSB];
    wire       write_reorder_sel = crc_control[WRITE_REORDER];
    wire       bit_reflect_sel   = crc_control[BIT_REFLECT];
    wire [4:0] poly_len_field    = crc_control[POLY_LEN_LSB+4:POLY_LEN_LSB];
    wire       crc_unit_enable   = crc_control[UNIT_ENABLE];
    wire       crc_append_sel    = crc_control[APPEND_BIT];
    wire       crc_type_sel      = crc_control[CRC_TYPE_BIT];
    wire [2:0] crc_channel_sel   = crc_control[CHANNEL_LSB+2:CHANNEL_LSB];

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire hit_control = (reg_addr == CRC_CONTROL_OFS);
    wire hit_status  = (reg_addr == CRC_STATUS_OFS);
    wire wr_control  = reg_write && hit_control;
    wire wr_status   = reg_write && hit_status;

    wire [31:0] masked_wdata = reg_wdata & CONTROL_MASK;
    // append held clear under write reorder
    wire        next_append  = masked_wdata[APPEND_BIT] && !masked_wdata[WRITE_REORDER];
    wire [31:0] next_control = {masked_wdata[31:APPEND_BIT+1], next_append,
                                masked_wdata[APPEND_BIT-1:0]};

    wire [31:0] status_word;
    assign status_word = {unaligned_err, {(15-LW){1'b0}}, fifo_level, routed_count};

    wire [31:0] read_mux = hit_control ? crc_control :
                           hit_status  ? status_word : 32'h0000_0000;

    // ------------------------------------------------------------
    // Data path steering
    // ------------------------------------------------------------
    logic fifo_in_ready;
    assign src_ready = fifo_in_ready;

    wire accept = src_valid && fifo_in_ready;
    wire routed = crc_unit_enable && (src_channel == crc_channel_sel);

    wire [31:0] ordered_data = reorder(src_data, byte_order_sel);
    // destination gets reordered data only under write reorder
    wire [31:0] dest_data    = (routed && write_reorder_sel) ? ordered_data : src_data;
    // reflection applies alike in both modes
    wire [31:0] feed_data    = bit_reflect_sel ? reflect(ordered_data) : ordered_data;
    wire        set_unaligned = accept && routed && write_reorder_sel && src_unaligned;

    assign crc_ip_mode  = crc_type_sel;
    // length ignored in IP header mode
    assign crc_poly_len = crc_type_sel ? 5'h00 : poly_len_field;
    assign crc_append   = crc_append_sel;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst)
            crc_control <= CONTROL_RESET;
        else if (wr_control)
            crc_control <= next_control;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata     <= 32'h0000_0000;
            routed_count  <= COUNT_RESET;
            unaligned_err <= 1'b0;
        end else begin
            reg_rdata <= reg_read ? read_mux : 32'h0000_0000;
            if (accept && routed)
                routed_count <= routed_count + 16'h0001;
            // flag misuse; a new event beats the clear
            if (set_unaligned)
                unaligned_err <= 1'b1;
            else if (wr_status && reg_wdata[STAT_UNALIGNED])
                unaligned_err <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            crc_feed_valid <= 1'b0;
            crc_feed_data  <= 32'h0000_0000;
        end else begin
            crc_feed_valid <= accept && routed;
            if (accept && routed)
                crc_feed_data <= feed_data;
        end
    end

    crc_stream_fifo #(
        .WIDTH (32),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (src_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (dest_data),
        .out_valid (dst_valid),
        .out_ready (dst_ready),
        .out_data  (dst_data),
        .level     (fifo_level)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_feed_word_swap;
        @(posedge clk) disable iff (rst)
        (accept && routed && byte_order_sel == ORDER_WORD_SWAP && !bit_reflect_sel)
        |=> crc_feed_valid && crc_feed_data == {$past(src_data[7:0]), $past(src_data[15:8]),
                                                $past(src_data[23:16]), $past(src_data[31:24])};
    endproperty
    a_feed_word_swap: assert property (p_feed_word_swap)
        else $error("word byte swap wrong on crc feed");

    property p_feed_half_swap;
        @(posedge clk) disable iff (rst)
        (accept && routed && byte_order_sel == ORDER_HALF_SWAP && !bit_reflect_sel)
        |=> crc_feed_data[31:16] == $past(src_data[15:0])
            && crc_feed_data[15:0] == $past(src_data[31:16]);
    endproperty
    a_feed_half_swap: assert property (p_feed_half_swap)
        else $error("half-word swap wrong on crc feed");

    property p_dest_plain;
        @(posedge clk) disable iff (rst)
        (src_valid && !(routed && write_reorder_sel)) |-> (dest_data == src_data);
    endproperty
    a_dest_plain: assert property (p_dest_plain)
        else $error("destination data altered without write reorder");

    property p_reflect_ip;
        @(posedge clk) disable iff (rst)
        (accept && routed && crc_type_sel && bit_reflect_sel && byte_order_sel == ORDER_KEEP)
        |=> crc_feed_data[31] == $past(src_data[0]) && crc_feed_data[0] == $past(src_data[31]);
    endproperty
    a_reflect_ip: assert property (p_reflect_ip)
        else $error("ip mode reflection wrong");

    property p_plain_lfsr;
        @(posedge clk) disable iff (rst)
        (accept && routed && !crc_type_sel && !bit_reflect_sel && byte_order_sel == ORDER_KEEP)
        |=> crc_feed_data == $past(src_data);
    endproperty
    a_plain_lfsr: assert property (p_plain_lfsr)
        else $error("lfsr msb-first feed altered");

    property p_mode_out;
        @(posedge clk) disable iff (rst)
        wr_control |=> crc_ip_mode == $past(reg_wdata[CRC_TYPE_BIT]);
    endproperty
    a_mode_out: assert property (p_mode_out)
        else $error("crc type not applied");

    property p_poly_ignored;
        @(posedge clk) disable iff (rst)
        crc_ip_mode |-> crc_poly_len == 5'h00;
    endproperty
    a_poly_ignored: assert property (p_poly_ignored)
        else $error("poly length visible in ip mode");

    property p_disabled;
        @(posedge clk) disable iff (rst)
        !crc_unit_enable |=> !crc_feed_valid;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("feed while unit disabled");

    property p_no_append;
        @(posedge clk) disable iff (rst)
        write_reorder_sel |-> !crc_append;
    endproperty
    a_no_append: assert property (p_no_append)
        else $error("append set under write reorder");

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        (reg_read && hit_control) |=> reg_rdata[23:13] == 11'h000 && reg_rdata[31:30] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("unimplemented control bits read non-zero");

    property p_channel;
        @(posedge clk) disable iff (rst)
        crc_feed_valid |-> $past(src_channel) == $past(crc_channel_sel);
    endproperty
    a_channel: assert property (p_channel)
        else $error("feed from unselected channel");

    property p_reset_zero;
        @(posedge clk) disable iff (rst)
        $past(rst) |-> crc_control == 32'h0000_0000 && !crc_feed_valid;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("control not zero after reset");

    property p_dest_reorder;
        @(posedge clk) disable iff (rst)
        (accept && routed && write_reorder_sel && byte_order_sel == ORDER_HALF_SWAP)
        |-> dest_data == {src_data[15:0], src_data[31:16]};
    endproperty
    a_dest_reorder: assert property (p_dest_reorder)
        else $error("destination half-words not swapped under write reorder");

    property p_unaligned_flag;
        @(posedge clk) disable iff (rst)
        set_unaligned |=> unaligned_err;
    endproperty
    a_unaligned_flag: assert property (p_unaligned_flag)
        else $error("unaligned word under write reorder not flagged");

    // Read data stand only in the cycle after each cycle of reg_read, so stale words never leak out
    property p_rdata_idle;
        @(posedge clk) disable iff (rst)
        !reg_read |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without a read");

    c_routed:    cover property (@(posedge clk) disable iff (rst) accept && routed);
    c_reorder:   cover property (@(posedge clk) disable iff (rst)
                                 accept && routed && write_reorder_sel);
    c_fifo_full: cover property (@(posedge clk) disable iff (rst) src_valid && !src_ready);
    c_unaligned: cover property (@(posedge clk) disable iff (rst) set_unaligned);
    c_ip_reflect: cover property (@(posedge clk) disable iff (rst)
                                  accept && routed && crc_type_sel && bit_reflect_sel);
endmodule // dma_crc_control

// ---- hw/crc_ctrl_pkg.sv ----
// Constants shared by the CRC control block and its stream buffer
package crc_ctrl_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] CRC_CONTROL_OFS = 4'h0;
    localparam logic [3:0] CRC_STATUS_OFS  = 4'h4;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int BYTE_ORDER_LSB = 28;
    localparam int WRITE_REORDER  = 27;
    localparam int BIT_REFLECT    = 24;
    localparam int POLY_LEN_LSB   = 8;
    localparam int UNIT_ENABLE    = 7;
    localparam int APPEND_BIT     = 6;
    localparam int CRC_TYPE_BIT   = 5;
    localparam int CHANNEL_LSB    = 0;

    // Writable bits; everything else reads zero
    localparam logic [31:0] CONTROL_MASK  = 32'h3900_1fe7;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_LEVEL_LSB = 16;
    localparam int STAT_UNALIGNED = 31;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Byte order codes
    // ------------------------------------------------------------
    localparam logic [1:0] ORDER_KEEP      = 2'h0;
    localparam logic [1:0] ORDER_WORD_SWAP = 2'h1;
    localparam logic [1:0] ORDER_HALF_SWAP = 2'h2;
    localparam logic [1:0] ORDER_HALF_BYTE = 2'h3;

    localparam int FIFO_DEPTH = 16;
endpackage

// ---- hw/crc_stream_fifo.sv ----
// Stream buffer with registered read data between CRC control and destination
`timescale 1ns/100ps
module crc_stream_fifo
    import crc_ctrl_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic      [WIDTH-1:0]         out_data,
    output logic      [$clog2(DEPTH):0]   level
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("crc_stream_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire push = in_valid && in_ready;
    wire pop  = (count != '0) && (!out_valid || out_ready);

    assign in_ready = (count != DEPTH[AW:0]);
    assign level    = count;

    always_ff @(posedge clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop) begin
                rd_ptr   <= rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
            end
            if (pop)
                out_valid <= 1'b1;
            else if (out_ready)
                out_valid <= 1'b0;
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // crc_stream_fifo

// ---- verification/dma_engine_model.sv ----
// Behavioural DMA engine: source word queue and a destination sink that can stall
`timescale 1ns/100ps
module dma_engine_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        stall,
    output logic             src_valid,
    input  wire logic        src_ready,
    output logic      [31:0] src_data,
    output logic      [2:0]  src_channel,
    output logic             src_unaligned,
    input  wire logic        dst_valid,
    output logic             dst_ready,
    input  wire logic [31:0] dst_data
);
    // Entries are {unaligned, channel, data}
    logic [35:0] send_q[$];
    logic [31:0] recv_q[$];

    initial begin
        src_valid     = 1'b0;
        src_data      = 32'h0000_0000;
        src_channel   = 3'h0;
        src_unaligned = 1'b0;
        dst_ready     = 1'b1;
    end

    // ------------------------------------------------------------
    // Word held until taken; idle data toggles so stale words never match
    // ------------------------------------------------------------
    // unaligned only when asked
    always @(posedge clk) begin
        if (dst_valid && dst_ready)
            recv_q.push_back(dst_data);
        if (src_valid && src_ready)
            void'(send_q.pop_front());
        if (!rst && send_q.size() > 0) begin
            src_valid <= 1'b1;
            {src_unaligned, src_channel, src_data} <= send_q[0];
        end else begin
            src_valid <= 1'b0;
            src_data  <= ~src_data;
        end
        dst_ready <= !stall;
    end
endmodule // dma_engine_model

// ---- verification/test_dma_crc_control.sv ----
// Self-checking bench for the CRC control block
`timescale 1ns/100ps
module test_dma_crc_control
    import crc_ctrl_pkg::*;
;
    typedef struct {
        logic [31:0] ctrl;
        logic [31:0] feed;
        logic [31:0] dst;
    } row_s;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        stall = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [31:0] reg_rdata, src_data, dst_data, crc_feed_data;
    logic        src_valid, src_ready, src_unaligned, dst_valid, dst_ready;
    logic        crc_feed_valid, crc_ip_mode, crc_append;
    logic [2:0]  src_channel;
    logic [4:0]  crc_poly_len;
    int          miscompares = 0;
    int          n_checks = 0;
    int          n_routed = 0;
    row_s        rows[8] = '{
        '{32'h0000_0081, 32'h1122_3344, 32'h1122_3344},
        '{32'h1000_0081, 32'h4433_2211, 32'h1122_3344},
        '{32'h2800_0081, 32'h3344_1122, 32'h3344_1122},
        '{32'h3800_0081, 32'h2211_4433, 32'h2211_4433},
        '{32'h0100_0081, 32'h22cc_4488, 32'h1122_3344},
        '{32'h0100_00a1, 32'h22cc_4488, 32'h1122_3344},
        '{32'h0000_1f81, 32'h1122_3344, 32'h1122_3344},
        '{32'h0000_1fa1, 32'h1122_3344, 32'h1122_3344}};

    always #4 clk = ~clk;

    dma_crc_control dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .src_valid, .src_ready, .src_data, .src_channel, .src_unaligned,
        .dst_valid, .dst_ready, .dst_data, .crc_feed_valid, .crc_feed_data,
        .crc_ip_mode, .crc_poly_len, .crc_append);
    dma_engine_model dma (.clk, .rst, .stall, .src_valid, .src_ready, .src_data,
        .src_channel, .src_unaligned, .dst_valid, .dst_ready, .dst_data);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // An idle edge after each write keeps strobes from being set twice at one edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
        check(reg_rdata, exp);
    endtask

    task automatic send(input logic [2:0] ch, input logic [31:0] d, input logic un,
                        input logic routed, input logic [31:0] feed, input logic [31:0] dst);
        logic fed;
        int   k;
        fed = 1'b0;
        dma.send_q.push_back({un, ch, d});
        for (k = 0; k < 20 && dma.recv_q.size() == 0; k++) begin
            @(posedge clk);
            if (crc_feed_valid === 1'b1) begin
                fed = 1'b1;
                check(crc_feed_data, feed);
            end
        end
        if (dma.recv_q.size() == 0) begin
            miscompares++;
            results();
        end
        check({31'h0, fed}, {31'h0, routed});
        if (routed)
            n_routed++;
        check(dma.recv_q.pop_front(), dst);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(CRC_CONTROL_OFS, 32'h0000_0000);
        rdc(CRC_STATUS_OFS, 32'h0000_0000);
        foreach (rows[i]) begin
            wr(CRC_CONTROL_OFS, rows[i].ctrl);
            check({31'h0, crc_ip_mode}, {31'h0, rows[i].ctrl[5]});
            check({27'h0, crc_poly_len}, rows[i].ctrl[5] ? 32'h0 : {27'h0, rows[i].ctrl[12:8]});
            send(3'h1, 32'h1122_3344, 1'b0, 1'b1, rows[i].feed, rows[i].dst);
        end
        // Reserved bits and the append lockout
        wr(CRC_CONTROL_OFS, 32'hffff_ffff);
        rdc(CRC_CONTROL_OFS, 32'h3900_1fa7);
        wr(CRC_CONTROL_OFS, 32'h0000_0040);
        rdc(CRC_CONTROL_OFS, 32'h0000_0040);
        check({31'h0, crc_append}, 32'h1);
        wr(4'hc, 32'hffff_ffff);
        rdc(4'h8, 32'h0000_0000);
        rdc(CRC_CONTROL_OFS, 32'h0000_0040);
        // Channel selection and enable
        wr(CRC_CONTROL_OFS, 32'h1800_0082);
        send(3'h1, 32'h1122_3344, 1'b0, 1'b0, 32'h0, 32'h1122_3344);
        send(3'h2, 32'h1122_3344, 1'b0, 1'b1, 32'h4433_2211, 32'h4433_2211);
        wr(CRC_CONTROL_OFS, 32'h1800_0002);
        send(3'h2, 32'h5566_7788, 1'b0, 1'b0, 32'h0, 32'h5566_7788);
        rdc(CRC_STATUS_OFS, {16'h0, n_routed[15:0]});
        // Unaligned word while write reorder is set
        wr(CRC_CONTROL_OFS, 32'h0800_0080);
        send(3'h0, 32'h0bad_f00d, 1'b1, 1'b1, 32'h0bad_f00d, 32'h0bad_f00d);
        rdc(CRC_STATUS_OFS, {1'b1, 15'h0, n_routed[15:0]});
        wr(CRC_STATUS_OFS, 32'h8000_0000);
        rdc(CRC_STATUS_OFS, {16'h0, n_routed[15:0]});
        // Fill the buffer against a stalled sink, then drain it
        wr(CRC_CONTROL_OFS, 32'h0000_0000);
        stall <= 1'b1;
        for (int i = 0; i < 18; i++)
            dma.send_q.push_back({4'h0, 32'ha000_0000 + i});
        for (int k = 0; k < 40 && src_ready !== 1'b0; k++)
            @(posedge clk);
        check({31'h0, src_ready}, 32'h0);
        if (src_ready !== 1'b0)
            results();
        rdc(CRC_STATUS_OFS, {11'h0, 5'd16, n_routed[15:0]});
        stall <= 1'b0;
        for (int k = 0; k < 80 && dma.recv_q.size() < 18; k++)
            @(posedge clk);
        check(dma.recv_q.size(), 32'd18);
        if (dma.recv_q.size() < 18)
            results();
        for (int i = 0; i < 18 && dma.recv_q.size() > 0; i++)
            check(dma.recv_q.pop_front(), 32'ha000_0000 + i);
        // Reset in mid-run clears the configuration
        wr(CRC_CONTROL_OFS, 32'h0000_0081);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(CRC_CONTROL_OFS, 32'h0000_0000);
        rdc(CRC_STATUS_OFS, 32'h0000_0000);
        results();
    end
endmodule // test_dma_crc_control
